// ---- logic/alc_cell.sv ----
// Adaptive logic cell: split tables, adders, registers, outputs
// Behaviour
// - Two split table halves share up to eight inputs, two functions.
// - Any six-input function; seven-input multiplexed pairs too.
// - Each register takes data, clock, enable, clears and loads.
// - Async load data comes from the fifth input of its half.
// - Combinational use bypasses the register, table drives outputs.
// - Two output sets, two routed outputs each, one also local.
// - Table drives one output while the register drives another.
// - Register output can feed back into the same cell's table.
// - Registered and unregistered results can appear together.
// - Exactly one of normal, extended, arithmetic, shared modes.
// - Eleven inputs steered: eight data, carry, share, chain.
// - Register controls come from cluster-wide signals; extended mode also clears the second register.
// - Normal mode: two four-input or five plus three functions.
// - Two five-input functions share inputs a and b.
// - Two six-input functions share four inputs and one table.
// - Upper pair feeds top register and outputs; lower pair bottom.
// - Lower pair in use leaves upper pair free for packing.
// - Lower sixth packs only when the six-input result bypasses.
// - Extended mode: 2-to-1 mux of two five-input functions.
// - Extended unregistered frees eighth input; second register off.
// - Clock enable low holds the registers unless an async clear or load acts.
`timescale 1ns/1ps
`default_nettype none
module alc_cell
   import alc_pkg::*;
#(
   parameter int TBL_IN = ALC_TBL_IN
)(
   // Clock and reset
   input  wire logic                    core_clk_in,
   input  wire logic                    rst_n_in,
   // Data inputs
   input  wire logic [3:0]              data_in,
   input  wire logic                    upper_fifth_in,
   input  wire logic                    upper_sixth_in,
   input  wire logic                    lower_fifth_in,
   input  wire logic                    lower_sixth_in,
   // Chain inputs
   input  wire logic                    carry_in,
   input  wire logic                    share_in,
   input  wire logic                    reg_chain_in,
   // Cluster controls
   input  wire logic                    clk_ena_in,
   input  wire logic                    sclr_in,
   input  wire logic                    sload_in,
   input  wire logic                    aclr_in,
   input  wire logic                    aload_in,
   // Static configuration
   input  wire alc_mode_type            cfg_mode_in,
   input  wire logic [ALC_TBL_BITS-1:0] cfg_upper_mask_in,
   input  wire logic [ALC_TBL_BITS-1:0] cfg_lower_mask_in,
   input  wire logic [ALC_SEL_BITS-1:0] cfg_upper_sel_in,
   input  wire logic [ALC_SEL_BITS-1:0] cfg_lower_sel_in,
   input  wire logic [3:0]              cfg_pack_in,
   input  wire logic [3:0]              cfg_route_reg_in,
   // Top output set
   output logic      [1:0]              top_route_out,
   output logic                         top_local_out,
   // Bottom output set
   output logic      [1:0]              bot_route_out,
   output logic                         bot_local_out,
   // Chain outputs
   output logic                         carry_out,
   output logic                         share_out,
   output logic                         reg_chain_out
);

   // Elaboration check
   if (TBL_IN != ALC_TBL_IN) begin : g_chk
      $error("table input count must be six");
   end

   logic [ALC_SRC_N-1:0] src;
   logic [5:0]           up_idx;
   logic [5:0]           lo_idx;
   logic                 q0;
   logic                 q1;
   logic                 up_tbl;
   logic                 lo_tbl;
   logic                 up_a;
   logic                 up_b;
   logic                 lo_a;
   logic                 lo_b;
   logic                 ext_f0;
   logic                 ext_f1;
   logic                 ext_out;
   logic                 s0;
   logic                 c0;
   logic                 s1;
   logic                 c1;
   logic                 top_comb;
   logic                 bot_comb;
   logic                 d0;
   logic                 d1;
   logic                 top_unreg;
   logic                 bot_unreg;
   logic                 second_cell_register_off;
   alc_pack_type         pk0;
   alc_pack_type         pk1;

   // Picks one of the ten table sources
   function automatic logic pick(input logic [ALC_SRC_N-1:0] s,
                                 input logic [ALC_SEL_W-1:0] sel);
      logic r;
      r = 1'b0;
      if (sel < 4'hA) begin
         r = s[sel];
      end
      return r;
   endfunction

   // Table source vector, register feedback on top
   assign src = {q1, q0, lower_sixth_in, lower_fifth_in,
                 upper_sixth_in, upper_fifth_in, data_in};

   // Per-half input steering
   for (genvar i = 0; i < ALC_TBL_IN; i++) begin : g_sel
      assign up_idx[i] = pick(src, cfg_upper_sel_in[i*ALC_SEL_W +: ALC_SEL_W]);
      assign lo_idx[i] = pick(src, cfg_lower_sel_in[i*ALC_SEL_W +: ALC_SEL_W]);
   end

   // Six-input lookups, one per half
   assign up_tbl = cfg_upper_mask_in[up_idx];
   assign lo_tbl = cfg_lower_mask_in[lo_idx];

   // Five-input sub-functions of each half
   assign up_a = cfg_upper_mask_in[{1'b0, up_idx[4:0]}];
   assign up_b = cfg_upper_mask_in[{1'b1, up_idx[4:0]}];
   assign lo_a = cfg_lower_mask_in[{1'b0, lo_idx[4:0]}];
   assign lo_b = cfg_lower_mask_in[{1'b1, lo_idx[4:0]}];

   // Seven-input multiplexed pair
   assign ext_f0  = up_a;
   assign ext_f1  = lo_a;
   assign ext_out = up_idx[5] ? ext_f1 : ext_f0;

   // Two full adders, mode picks operands
   always_comb begin
      s0 = 1'b0;
      c0 = 1'b0;
      s1 = 1'b0;
      c1 = 1'b0;
      if (cfg_mode_in == ALC_SHARED) begin
         s0 = up_a ^ share_in ^ carry_in;
         c0 = (up_a & share_in) | (carry_in & (up_a ^ share_in));
         s1 = lo_a ^ up_b ^ c0;
         c1 = (lo_a & up_b) | (c0 & (lo_a ^ up_b));
      end else begin
         s0 = up_a ^ up_b ^ carry_in;
         c0 = (up_a & up_b) | (carry_in & (up_a ^ up_b));
         s1 = lo_a ^ lo_b ^ c0;
         c1 = (lo_a & lo_b) | (c0 & (lo_a ^ lo_b));
      end
   end

   // Mode selects the combinational results
   always_comb begin
      top_comb  = 1'b0;
      bot_comb  = 1'b0;
      carry_out = 1'b0;
      share_out = 1'b0;
      unique case (cfg_mode_in)
         ALC_NORMAL: begin
            top_comb = up_tbl;
            bot_comb = lo_tbl;
         end
         ALC_EXTENDED: begin
            top_comb = ext_out;
         end
         ALC_ARITH: begin
            top_comb  = s0;
            bot_comb  = s1;
            carry_out = c1;
         end
         ALC_SHARED: begin
            top_comb  = s0;
            bot_comb  = s1;
            carry_out = c1;
            share_out = lo_b;
         end
      endcase
   end

   // Register data selection and packing
   assign pk0       = alc_pack_type'(cfg_pack_in[ALC_PK0_LSB +: 2]);
   assign pk1       = alc_pack_type'(cfg_pack_in[ALC_PK1_LSB +: 2]);
   assign top_unreg = cfg_route_reg_in[ALC_RT_TOP +: 2] == 2'b00;
   assign bot_unreg = cfg_route_reg_in[ALC_RT_BOT +: 2] == 2'b00;
   assign second_cell_register_off  = cfg_mode_in == ALC_EXTENDED;

   always_comb begin
      d0 = top_comb;
      unique case (pk0)
         ALC_PK_COMB:  d0 = top_comb;
         ALC_PK_FIFTH: d0 = upper_fifth_in;
         ALC_PK_SIXTH: d0 = second_cell_register_off ? (top_unreg ? lower_sixth_in : top_comb)
                                     : upper_sixth_in;
         ALC_PK_CHAIN: d0 = reg_chain_in;
      endcase
   end

   always_comb begin
      d1 = bot_comb;
      unique case (pk1)
         ALC_PK_COMB:  d1 = bot_comb;
         ALC_PK_FIFTH: d1 = lower_fifth_in;
         ALC_PK_SIXTH: d1 = bot_unreg ? lower_sixth_in : bot_comb;
         ALC_PK_CHAIN: d1 = q0;
      endcase
   end

   // First cell register
   alc_cell_reg u_first_cell_register (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .ena_in      (clk_ena_in),
      .sclr_in     (sclr_in),
      .sload_in    (sload_in),
      .aclr_in     (aclr_in),
      .aload_in    (aload_in),
      .d_in        (d0),
      .sdata_in    (upper_fifth_in),
      .adata_in    (upper_fifth_in),
      .q_out       (q0)
   );

   // Second cell register, held clear in extended mode
   alc_cell_reg u_second_cell_register (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .ena_in      (clk_ena_in),
      .sclr_in     (sclr_in),
      .sload_in    (sload_in),
      .aclr_in     (aclr_in | second_cell_register_off),
      .aload_in    (aload_in),
      .d_in        (d1),
      .sdata_in    (lower_fifth_in),
      .adata_in    (lower_fifth_in),
      .q_out       (q1)
   );

   // Output driver sets, each route picks register or bypass
   assign top_route_out[0] = cfg_route_reg_in[0] ? q0 : top_comb;
   assign top_route_out[1] = cfg_route_reg_in[1] ? q0 : top_comb;
   assign top_local_out    = top_route_out[0];
   assign bot_route_out[0] = cfg_route_reg_in[2] ? q1 : bot_comb;
   assign bot_route_out[1] = cfg_route_reg_in[3] ? q1 : bot_comb;
   assign bot_local_out    = bot_route_out[0];
   assign reg_chain_out    = q1;

   // Checks
   bypass_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !cfg_route_reg_in[0] |-> top_route_out[0] == top_comb)
      else $error("bypass not combinational");
   normal_tbl_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cfg_mode_in == ALC_NORMAL && !cfg_route_reg_in[2]
      |-> bot_route_out[0] == cfg_lower_mask_in[lo_idx])
      else $error("lower table not on bottom set");
   ext_mux_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cfg_mode_in == ALC_EXTENDED && !cfg_route_reg_in[0]
      |-> top_route_out[0] == (up_idx[5] ? lo_a : up_a))
      else $error("extended mux wrong");
   ext_second_cell_register_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (cfg_mode_in == ALC_EXTENDED) [*2] |-> !reg_chain_out)
      else $error("second register active");
   local_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      top_local_out == top_route_out[0] && bot_local_out == bot_route_out[0])
      else $error("local output mismatch");
   pack_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cfg_mode_in == ALC_NORMAL && pk0 == ALC_PK_FIFTH && clk_ena_in
      && !aclr_in && !aload_in && !sclr_in && !sload_in
      ##1 cfg_route_reg_in[1] && !aclr_in && !aload_in
      |-> top_route_out[1] == $past(upper_fifth_in))
      else $error("packed register lost data");
   both_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cfg_route_reg_in[1:0] == 2'b10 |-> top_route_out[0] == top_comb
      && top_route_out[1] == q0) else $error("dual outputs wrong");
   carry_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cfg_mode_in == ALC_NORMAL |-> !carry_out && !share_out)
      else $error("chain outputs active");
   share_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cfg_mode_in != ALC_SHARED |-> !share_out) else $error("share chain active");
   hold_cell_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !clk_ena_in && !aclr_in && !aload_in && !second_cell_register_off ##1 !aclr_in && !aload_in
      |-> $stable(reg_chain_out)) else $error("register moved");

   // Packing checks, asynchronous controls quiet on both edges
   sixth_pack_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !second_cell_register_off && pk1 == ALC_PK_SIXTH && bot_unreg && clk_ena_in
      && !aclr_in && !aload_in && !sclr_in && !sload_in
      ##1 !aclr_in && !aload_in |-> reg_chain_out == $past(lower_sixth_in))
      else $error("lower sixth not packed");
   ext_pack_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      second_cell_register_off && pk0 == ALC_PK_SIXTH && top_unreg && clk_ena_in
      && !aclr_in && !aload_in && !sclr_in && !sload_in
      ##1 !aclr_in && !aload_in |-> q0 == $past(lower_sixth_in))
      else $error("eighth input not packed");
   chain_in_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      pk0 == ALC_PK_CHAIN && clk_ena_in && !aclr_in && !aload_in && !sclr_in && !sload_in
      ##1 !aclr_in && !aload_in |-> q0 == $past(reg_chain_in))
      else $error("register chain not taken");

   ext_c: cover property (@(posedge core_clk_in) cfg_mode_in == ALC_EXTENDED);
   arith_c: cover property (@(posedge core_clk_in) cfg_mode_in == ALC_ARITH && carry_out);
   fb_c: cover property (@(posedge core_clk_in)
      cfg_upper_sel_in[ALC_SEL_W-1:0] == ALC_SRC_Q0 && cfg_route_reg_in[0]);
   pack_c: cover property (@(posedge core_clk_in) pk0 == ALC_PK_SIXTH && second_cell_register_off);

endmodule
`default_nettype wire

// ---- logic/alc_pkg.sv ----
// Shared constants and types of the adaptive logic cell
package alc_pkg;

   // Operating modes of the cell
   typedef enum logic [1:0] {
      ALC_NORMAL   = 2'b00,
      ALC_EXTENDED = 2'b01,
      ALC_ARITH    = 2'b10,
      ALC_SHARED   = 2'b11
   } alc_mode_type;

   // Register data source per register
   typedef enum logic [1:0] {
      ALC_PK_COMB  = 2'b00,
      ALC_PK_FIFTH = 2'b01,
      ALC_PK_SIXTH = 2'b10,
      ALC_PK_CHAIN = 2'b11
   } alc_pack_type;

   // Table geometry
   localparam int ALC_TBL_IN   = 6;
   localparam int ALC_TBL_BITS = 64;
   localparam int ALC_SEL_W    = 4;
   localparam int ALC_SRC_N    = 10;
   localparam int ALC_SEL_BITS = 24;

   // Source selector codes above the eight data inputs
   localparam logic [3:0] ALC_SRC_Q0 = 4'h8;
   localparam logic [3:0] ALC_SRC_Q1 = 4'h9;

   // Field positions inside the packing and routing words
   localparam int ALC_PK0_LSB = 0;
   localparam int ALC_PK1_LSB = 2;
   localparam int ALC_RT_TOP  = 0;
   localparam int ALC_RT_BOT  = 2;

   // Register reset value
   localparam logic ALC_REG_RST = 1'b0;

endpackage

// ---- logic/alc_cell_reg.sv ----
// One cell register with cluster-wide controls
`timescale 1ns/1ps
`default_nettype none
module alc_cell_reg
   import alc_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   // Cluster controls
   input  wire logic ena_in,
   input  wire logic sclr_in,
   input  wire logic sload_in,
   input  wire logic aclr_in,
   input  wire logic aload_in,
   // Data
   input  wire logic d_in,
   input  wire logic sdata_in,
   input  wire logic adata_in,
   // State
   output logic      q_out
);

   logic q_q;
   logic q_d;

   // Next state by control priority
   always_comb begin
      q_d = q_q;
      if (aclr_in) begin
         q_d = 1'b0;
      end else if (aload_in) begin
         q_d = adata_in;
      end else if (!ena_in) begin
         q_d = q_q;
      end else if (sclr_in) begin
         q_d = 1'b0;
      end else if (sload_in) begin
         q_d = sdata_in;
      end else begin
         q_d = d_in;
      end
   end

   // State register
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         q_q <= ALC_REG_RST;
      end else begin
         q_q <= q_d;
      end
   end

   // Asynchronous controls act at once on the output
   assign q_out = aclr_in ? 1'b0 : (aload_in ? adata_in : q_q);

   // Checks
   aclr_wins_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      aclr_in |-> !q_out ##1 !q_q) else $error("async clear ignored");
   aload_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !aclr_in && aload_in |-> q_out == adata_in) else $error("async load wrong");
   hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !aclr_in && !aload_in && !ena_in |=> $stable(q_q)) else $error("no hold");
   sclr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !aclr_in && !aload_in && ena_in && sclr_in |=> !q_q) else $error("sync clear");
   sload_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !aclr_in && !aload_in && ena_in && !sclr_in && sload_in
      |=> q_q == $past(sdata_in)) else $error("sync load wrong");
   capture_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !aclr_in && !aload_in && ena_in && !sclr_in && !sload_in
      |=> q_q == $past(d_in)) else $error("capture wrong");
   sload_c: cover property (@(posedge core_clk_in) ena_in && sload_in && !sclr_in);

endmodule
`default_nettype wire

// ---- testbench/alc_nbr_model.sv ----
// Preceding cell model: register chain source, carry and shared chain drivers
`timescale 1ns/1ps
`default_nettype none
module alc_nbr_model (
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   // Requests from the bench
   input  wire logic shift_in,
   input  wire logic bit_in,
   input  wire logic carry_req_in,
   input  wire logic share_req_in,
   // Toward the cell
   output logic      carry_out,
   output logic      share_out,
   output logic      chain_out
);
   logic chain_q;
   logic chain_d;

   // Own register takes a bench bit when asked
   always_comb begin
      chain_d = shift_in ? bit_in : chain_q;
   end

   // Cleared with the cell so both sides start alike
   always_ff @(posedge core_clk_in) begin
      chain_q <= rst_n_in ? chain_d : 1'h0;
   end

   // Chain outputs of the preceding cell
   assign chain_out = chain_q;
   assign carry_out = carry_req_in;
   assign share_out = share_req_in;
endmodule
`default_nettype wire

// ---- testbench/alc_cell_tb.sv ----
// Self-checking bench of the adaptive logic cell
`timescale 1ns/1ps
`default_nettype none
module alc_cell_tb
   import alc_pkg::*;
;
   localparam logic [63:0] MU    = 64'h9C3A_F05E_61D7_2B84;
   localparam logic [63:0] ML    = 64'h47E1_B92C_D068_5FA3;
   localparam logic [63:0] HALF  = 64'hFFFF_FFFF_0000_0000;
   localparam logic [23:0] SEL_U = 24'h543210;
   logic         clk   = 1'h0;
   logic         rst_n = 1'h0;
   logic  [7:0]  ins   = 8'h00;
   logic  [4:0]  ctl   = 5'h04;
   alc_mode_type mode  = ALC_NORMAL;
   logic  [63:0] umask = 64'h0;
   logic  [63:0] lmask = 64'h0;
   logic  [23:0] usel  = 24'h543210;
   logic  [3:0]  pack  = 4'h0;
   logic  [3:0]  route = 4'h0;
   logic         shift = 1'h0;
   logic         sbit  = 1'h0;
   logic         creq  = 1'h0;
   logic         sreq  = 1'h0;
   logic         cin, sin, chn, top_l, bot_l, cout, sout, rco;
   logic  [1:0]  top_r, bot_r;
   int           n_errors    = 0;
   int           checks_done = 0;

   // 10 MHz clock
   always #50 clk = ~clk;

   alc_nbr_model u_nbr (.core_clk_in (clk), .rst_n_in (rst_n), .shift_in (shift),
      .bit_in (sbit), .carry_req_in (creq), .share_req_in (sreq),
      .carry_out (cin), .share_out (sin), .chain_out (chn));

   alc_cell u_dut (.core_clk_in (clk), .rst_n_in (rst_n), .data_in (ins[3:0]),
      .upper_fifth_in (ins[4]), .upper_sixth_in (ins[5]),
      .lower_fifth_in (ins[6]), .lower_sixth_in (ins[7]),
      .carry_in (cin), .share_in (sin), .reg_chain_in (chn),
      .clk_ena_in (ctl[2]), .sclr_in (ctl[1]), .sload_in (ctl[0]),
      .aclr_in (ctl[4]), .aload_in (ctl[3]),
      .cfg_mode_in (mode), .cfg_upper_mask_in (umask), .cfg_lower_mask_in (lmask),
      .cfg_upper_sel_in (usel), .cfg_lower_sel_in (24'h763210),
      .cfg_pack_in (pack), .cfg_route_reg_in (route),
      .top_route_out (top_r), .top_local_out (top_l),
      .bot_route_out (bot_r), .bot_local_out (bot_l),
      .carry_out (cout), .share_out (sout), .reg_chain_out (rco));

   // Drive just after the rising edge
   task automatic step();
      @(posedge clk);
      #1;
   endtask

   // Bit comparison
   task automatic chk(input string nm, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", nm, exp, got);
      end
   endtask

   // New configuration, applied only while reset is held
   task automatic cfg(input alc_mode_type m, input logic [63:0] mu, input logic [63:0] ml,
                      input logic [23:0] us, input logic [3:0] pk, input logic [3:0] rt);
      rst_n = 1'h0;
      ctl = 5'h04;
      ins = 8'h00;
      mode = m;
      umask = mu;
      lmask = ml;
      usel = us;
      pack = pk;
      route = rt;
      step();
      step();
      rst_n = 1'h1;
   endtask

   // Expected next register state: aclr, aload, hold, sclr, sload, capture
   function automatic logic nxt(input logic [4:0] c, input logic ad, input logic d,
                                input logic q);
      if (c[4]) return 1'h0;
      if (c[3]) return ad;
      if (!c[2]) return q;
      if (c[1]) return 1'h0;
      if (c[0]) return ad;
      return d;
   endfunction

   // Every input pattern through both tables, registers bypassed
   task automatic t_comb();
      cfg(ALC_NORMAL, MU, ML, SEL_U, 4'h0, 4'h0);
      for (int i = 0; i < 256; i++) begin
         ins = 8'(i);
         #1;
         chk("top comb", MU[{ins[5:4], ins[3:0]}], top_r[0]);
         chk("top second", MU[ins[5:0]], top_r[1]);
         chk("top local", MU[ins[5:0]], top_l);
         chk("bot comb", ML[{ins[7:6], ins[3:0]}], bot_r[0]);
         chk("bot local", ML[{ins[7:6], ins[3:0]}], bot_l);
         chk("chains idle", 1'h0, cout | sout);
         step();
      end
   endtask

   // All control combinations against both registers
   task automatic t_regs();
      logic q0, q1, c0, c1;
      cfg(ALC_NORMAL, MU, ML, SEL_U, 4'h0, 4'hA);
      q0 = 1'h0;
      q1 = 1'h0;
      for (int i = 0; i < 96; i++) begin
         ins = 8'(i * 37);
         ctl = 5'(i);
         #1;
         c0 = MU[{ins[5:4], ins[3:0]}];
         c1 = ML[{ins[7:6], ins[3:0]}];
         chk("top comb", c0, top_r[0]);
         chk("top reg", ctl[4] ? 1'h0 : ctl[3] ? ins[4] : q0, top_r[1]);
         chk("bot reg", ctl[4] ? 1'h0 : ctl[3] ? ins[6] : q1, bot_r[1]);
         q0 = nxt(ctl, ins[4], c0, q0);
         q1 = nxt(ctl, ins[6], c1, q1);
         step();
      end
      ctl = 5'h04;
   endtask

   // Register packing, feedback and chain
   task automatic t_pack();
      logic n, q0, q1;
      cfg(ALC_NORMAL, MU, ML, SEL_U, 4'h9, 4'h2);
      for (int i = 0; i < 8; i++) begin
         ins = 8'(i * 53);
         step();
         chk("pack fifth", ins[4], top_r[1]);
         chk("pack sixth", ins[7], rco);
      end
      cfg(ALC_NORMAL, MU, ML, SEL_U, 4'h9, 4'hA);
      for (int i = 0; i < 8; i++) begin
         ins = 8'(i * 53);
         step();
         chk("pack blocked", ML[{ins[7:6], ins[3:0]}], rco);
      end
      cfg(ALC_NORMAL, MU, ML, SEL_U, 4'h2, 4'h2);
      for (int i = 0; i < 8; i++) begin
         ins = 8'(i * 53);
         step();
         chk("pack upper sixth", ins[5], top_r[1]);
      end
      cfg(ALC_EXTENDED, 64'hAAAA_AAAA_AAAA_AAAA, ML, 24'h543218, 4'h2, 4'h0);
      for (int i = 0; i < 8; i++) begin
         ins = 8'(i * 53) & 8'hDF;
         step();
         chk("ext pack", ins[7], top_r[0]);
      end
      cfg(ALC_NORMAL, 64'hAAAA_AAAA_AAAA_AAAA, ML, 24'h543218, 4'hF, 4'h0);
      n = 1'h0;
      q0 = 1'h0;
      q1 = 1'h0;
      for (int i = 0; i < 12; i++) begin
         shift = 1'h1;
         sbit = 1'(12'hB36 >> i);
         step();
         q1 = q0;
         q0 = n;
         n = sbit;
         chk("feedback", q0, top_r[0]);
         chk("chain out", q1, rco);
      end
      shift = 1'h0;
   endtask

   // Seven-input multiplexer, second register unavailable
   task automatic t_ext();
      cfg(ALC_EXTENDED, MU, ML, SEL_U, 4'h0, 4'h8);
      for (int i = 0; i < 256; i++) begin
         ins = 8'(i);
         #1;
         chk("ext mux", ins[5] ? ML[{1'h0, ins[6], ins[3:0]}]
                               : MU[{1'h0, ins[4], ins[3:0]}], top_r[0]);
         chk("ext bot comb", 1'h0, bot_r[0]);
         chk("ext bot reg", 1'h0, bot_r[1]);
         step();
      end
   endtask

   // Adder carries from the preceding cell's chains
   task automatic t_arith();
      cfg(ALC_ARITH, HALF, HALF, SEL_U, 4'h0, 4'h0);
      for (int i = 0; i < 4; i++) begin
         creq = i[0];
         sreq = i[1];
         step();
         chk("arith carry", i[0], cout);
         chk("arith sum", ~i[0], top_r[0]);
      end
      cfg(ALC_SHARED, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF, SEL_U, 4'h0, 4'h0);
      for (int i = 0; i < 4; i++) begin
         creq = i[0];
         sreq = i[1];
         step();
         chk("shared carry", i[0] & i[1], cout);
         chk("shared out", 1'h1, sout);
         chk("shared sum", i[0] ^ i[1], top_r[0]);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (16) step();
      rst_n = 1'h1;
      t_regs();
      t_comb();
      t_pack();
      t_ext();
      t_arith();
      finish_test();
   end

   // Watchdog well beyond the expected run of about 700 cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
